// File: quad_defines.svh
// Timing counts, line indices and reset values for the quadrature link
`ifndef QUAD_DEFINES_SVH
`define QUAD_DEFINES_SVH

`define CLK_PERIOD_NS 8
`define FAULT_HOLD_MS 20
`define FAULT_HOLD_CYC ((`FAULT_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_EDGE_NS 32
`define MIN_EDGE_CYC ((`MIN_EDGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COUNTS_PER_REV 4096
`define REF_PERIOD_DEF 0
`define QUAD_BOTH_HIGH 2'h2

`define SYNC_LINES 10
`define IDX_A 0
`define IDX_B 1
`define IDX_REF 2
`define IDX_FAULT 3
`define IDX_U 4
`define IDX_V 5
`define IDX_W 6
`define IDX_L1 7
`define IDX_L2 8
`define IDX_HOME 9
`define SYNC_RST 10'h008

`endif

// File: quad_pkg.sv
// Shared types for the quadrature encoder and its receiver
package quad_pkg;

    typedef enum logic [1:0] {
        EVAL_X1 = 2'b00,
        EVAL_X2 = 2'b01,
        EVAL_X4 = 2'b10
    } eval_mode_t;

    typedef enum logic [1:0] {
        COMM_2X180 = 2'b00,
        COMM_3X120 = 2'b01,
        COMM_4X90 = 2'b10
    } comm_div_t;

    typedef enum logic {
        FAULT_OK = 1'b0,
        FAULT_HOLD = 1'b1
    } fault_state_t;

endpackage : quad_pkg

// File: quad_link_if.sv
// Encoder output lines shared by encoder and receiver
`timescale 1ns/1ps
interface quad_link_if;
    logic quad_channel_a;
    logic quad_channel_a_n;
    logic quad_channel_b;
    logic quad_channel_b_n;
    logic ref_pulse;
    logic ref_pulse_n;
    logic fault_n;
    logic comm_u;
    logic comm_u_n;
    logic comm_v;
    logic comm_v_n;
    logic comm_w;
    logic comm_w_n;
    logic limit_out_1;
    logic limit_out_2;
    logic home_out;

    modport encoder (
        output quad_channel_a, quad_channel_a_n, quad_channel_b, quad_channel_b_n,
        output ref_pulse, ref_pulse_n, fault_n,
        output comm_u, comm_u_n, comm_v, comm_v_n, comm_w, comm_w_n,
        output limit_out_1, limit_out_2, home_out
    );

    modport receiver (
        input quad_channel_a, quad_channel_a_n, quad_channel_b, quad_channel_b_n,
        input ref_pulse, ref_pulse_n, fault_n,
        input comm_u, comm_u_n, comm_v, comm_v_n, comm_w, comm_w_n,
        input limit_out_1, limit_out_2, home_out
    );
endinterface : quad_link_if

// File: quad_encoder.sv
// Encoder end: quadrature, reference, fault, commutation and limit lines
`timescale 1ns/1ps
`include "quad_defines.svh"

module quad_encoder #(
    parameter int POS_W = 32,
    parameter int CPR_W = 12,
    parameter int COUNTS_PER_REV = `COUNTS_PER_REV,
    parameter int REF_PERIOD = `REF_PERIOD_DEF,
    parameter int MIN_EDGE_CYCLES = `MIN_EDGE_CYC,
    parameter int unsigned FAULT_HOLD_CYCLES = `FAULT_HOLD_CYC,
    parameter bit single_ended_variant = 1'b0,
    parameter bit POS_DETECT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step_req,
    input wire logic step_dir,
    input wire logic malfunction,
    input wire quad_pkg::comm_div_t comm_div,
    input wire logic magnet_n,
    input wire logic magnet_s,
    input wire logic home_track,
    output logic step_ready,
    output logic [POS_W-1:0] position,
    output logic fault_active,
    quad_link_if.encoder link
);
    import quad_pkg::*;

    localparam int GAP_W = 8;
    localparam int PW = CPR_W + 3;
    localparam logic CMP_RST = !single_ended_variant;

    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic [CPR_W-1:0] mech;
        logic [GAP_W-1:0] gap;
        fault_state_t fst;
        logic [31:0] hold;
        logic ready;
        logic a;
        logic an;
        logic b;
        logic bn;
        logic r;
        logic rn;
        logic fault_n;
        logic u;
        logic un;
        logic v;
        logic vn;
        logic w;
        logic wn;
        logic l1;
        logic l2;
        logic home;
    } enc_state_t;

    localparam enc_state_t RST_STATE = '{
        pos: '0,
        mech: '0,
        gap: '0,
        fst: FAULT_OK,
        hold: 32'h0000_0000,
        ready: 1'b1,
        a: 1'b0,
        an: CMP_RST,
        b: 1'b0,
        bn: CMP_RST,
        r: 1'b0,
        rn: CMP_RST,
        fault_n: 1'b1,
        default: 1'b0
    };

    enc_state_t q;
    enc_state_t d;

    logic [2:0] seg_n;
    logic [1:0] seg;

    // Segment count for the selected commutation division
    function automatic logic [2:0] comm_count(input comm_div_t div);
        case (div)
            COMM_2X180: comm_count = 3'h2;
            COMM_3X120: comm_count = 3'h3;
            COMM_4X90: comm_count = 3'h4;
            default: comm_count = 3'h2;
        endcase
    endfunction : comm_count

    // Segment index of a mechanical position; compares avoid a divider
    function automatic logic [1:0] seg_of(input logic [CPR_W-1:0] m, input logic [2:0] n);
        logic [PW-1:0] prod;
        logic [PW-1:0] rev;
        prod = PW'(m) * PW'(n);
        rev = PW'(COUNTS_PER_REV);
        if (prod >= rev + rev + rev)
            seg_of = 2'h3;
        else if (prod >= rev + rev)
            seg_of = 2'h2;
        else if (prod >= rev)
            seg_of = 2'h1;
        else
            seg_of = 2'h0;
    endfunction : seg_of

    // Complement line, held low on the single-ended variant
    function automatic logic compl(input logic x);
        compl = single_ended_variant ? 1'b0 : ~x;
    endfunction : compl

    always_comb
    begin
        d = q;
        seg_n = comm_count(comm_div);
        seg = 2'h0;

        if (q.gap != '0)
        begin
            d.gap = q.gap - GAP_W'(1);
        end

        // Spacing keeps each edge at least the minimum separation apart
        if (step_req && q.gap == '0)
        begin
            d.gap = GAP_W'(MIN_EDGE_CYCLES - 1);
            if (step_dir)
            begin
                d.pos = q.pos + POS_W'(1);
                d.mech = (q.mech == CPR_W'(COUNTS_PER_REV - 1)) ? '0 : q.mech + CPR_W'(1);
            end
            else
            begin
                d.pos = q.pos - POS_W'(1);
                d.mech = (q.mech == '0) ? CPR_W'(COUNTS_PER_REV - 1) : q.mech - CPR_W'(1);
            end
        end
        d.ready = (d.gap == '0);

        // forward sequence 00,10,11,01 so B lags
        d.a = d.pos[1] ^ d.pos[0];
        d.b = d.pos[1];

        d.r = (d.pos[POS_W-1:2] == (POS_W-2)'(REF_PERIOD)) && (d.pos[1:0] == `QUAD_BOTH_HIGH);

        d.an = compl(d.a);
        d.bn = compl(d.b);
        d.rn = compl(d.r);

        case (q.fst)
            FAULT_OK:
            begin
                if (malfunction)
                begin
                    d.fst = FAULT_HOLD;
                    d.hold = FAULT_HOLD_CYCLES - 32'h0000_0001;
                    d.fault_n = 1'b0;
                end
            end
            FAULT_HOLD:
            begin
                if (q.hold != 32'h0000_0000)
                begin
                    d.hold = q.hold - 32'h0000_0001;
                end
                else if (!malfunction)
                begin
                    d.fst = FAULT_OK;
                    d.fault_n = 1'b1;
                end
            end
            default:
            begin
                d.fst = FAULT_OK;
                d.fault_n = 1'b1;
            end
        endcase

        // phase k high in segment k mod n
        seg = seg_of(d.mech, seg_n);
        d.u = (seg == 2'h0);
        d.v = (seg == 2'(3'h1 % seg_n));
        d.w = (seg == 2'(3'h2 % seg_n));
        d.un = ~d.u;
        d.vn = ~d.v;
        d.wn = ~d.w;

        // north magnet trips limit 1, south limit 2
        d.l1 = magnet_n;
        d.l2 = magnet_s;

        // homing track on its own line
        d.home = POS_DETECT ? home_track : 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= RST_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    assign step_ready = q.ready;
    assign position = q.pos;
    assign fault_active = ~q.fault_n;

    assign link.quad_channel_a = q.a;
    assign link.quad_channel_a_n = q.an;
    assign link.quad_channel_b = q.b;
    assign link.quad_channel_b_n = q.bn;
    assign link.ref_pulse = q.r;
    assign link.ref_pulse_n = q.rn;
    assign link.fault_n = q.fault_n;
    assign link.comm_u = q.u;
    assign link.comm_u_n = q.un;
    assign link.comm_v = q.v;
    assign link.comm_v_n = q.vn;
    assign link.comm_w = q.w;
    assign link.comm_w_n = q.wn;
    assign link.limit_out_1 = q.l1;
    assign link.limit_out_2 = q.l2;
    assign link.home_out = q.home;

endmodule : quad_encoder

// File: quad_receiver.sv
// Receiver end: synchronises encoder lines, counts edges, reacts to faults
`timescale 1ns/1ps
`include "quad_defines.svh"

module quad_receiver #(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire quad_pkg::eval_mode_t eval_mode,
    input wire logic err_clear,
    quad_link_if.receiver link,
    output logic [POS_W-1:0] position,
    output logic direction,
    output logic [POS_W-1:0] ref_position,
    output logic ref_hit,
    output logic count_error,
    output logic shutdown,
    output logic limit_1,
    output logic limit_2,
    output logic home,
    output logic comm_u,
    output logic comm_v,
    output logic comm_w
);
    import quad_pkg::*;

    localparam int N = `SYNC_LINES;

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] filt;
        logic [POS_W-1:0] pos;
        logic [POS_W-1:0] ref_pos;
        logic dir;
        logic err;
        logic hit;
        logic shut;
    } rx_state_t;

    localparam rx_state_t RST_STATE = '{
        s1: `SYNC_RST,
        s2: `SYNC_RST,
        s3: `SYNC_RST,
        filt: `SYNC_RST,
        default: '0
    };

    rx_state_t q;
    rx_state_t d;

    logic [N-1:0] lines;
    logic a_ch;
    logic b_ch;
    logic fwd;
    logic cnt;
    logic qual_old;
    logic qual_new;

    // Complement lines are ignored so the single-ended variant works too
    assign lines = {link.home_out, link.limit_out_2, link.limit_out_1, link.comm_w,
                    link.comm_v, link.comm_u, link.fault_n, link.ref_pulse,
                    link.quad_channel_b, link.quad_channel_a};

    always_comb
    begin
        d = q;
        fwd = 1'b0;
        cnt = 1'b0;

        d.s1 = lines;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // level accepted once two stages agree
        // two-cycle stability keeps margin on edge spacing
        for (int i = 0; i < N; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                d.filt[i] = q.s3[i];
            end
        end

        a_ch = d.filt[`IDX_A] ^ q.filt[`IDX_A];
        b_ch = d.filt[`IDX_B] ^ q.filt[`IDX_B];
        d.hit = 1'b0;

        if (err_clear)
        begin
            d.err = 1'b0;
        end

        // undecodable double change, set beats clear
        if (a_ch && b_ch)
        begin
            d.err = 1'b1;
        end
        else if (a_ch || b_ch)
        begin
            fwd = a_ch ? (d.filt[`IDX_A] != d.filt[`IDX_B])
                       : (d.filt[`IDX_A] == d.filt[`IDX_B]);
            case (eval_mode)
                EVAL_X4: cnt = 1'b1;
                EVAL_X2: cnt = a_ch;
                EVAL_X1: cnt = a_ch && !d.filt[`IDX_B];
                default: cnt = 1'b0;
            endcase
            d.dir = fwd;
            if (cnt)
            begin
                d.pos = fwd ? q.pos + POS_W'(1) : q.pos - POS_W'(1);
            end
        end

        // reference only while both channels high
        qual_new = d.filt[`IDX_REF] & d.filt[`IDX_A] & d.filt[`IDX_B];
        qual_old = q.filt[`IDX_REF] & q.filt[`IDX_A] & q.filt[`IDX_B];
        if (qual_new && !qual_old)
        begin
            d.ref_pos = d.pos;
            d.hit = 1'b1;
        end

        d.shut = ~d.filt[`IDX_FAULT];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= RST_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    assign position = q.pos;
    assign direction = q.dir;
    assign ref_position = q.ref_pos;
    assign ref_hit = q.hit;
    assign count_error = q.err;
    assign shutdown = q.shut;
    assign limit_1 = q.filt[`IDX_L1];
    assign limit_2 = q.filt[`IDX_L2];
    assign home = q.filt[`IDX_HOME];
    assign comm_u = q.filt[`IDX_U];
    assign comm_v = q.filt[`IDX_V];
    assign comm_w = q.filt[`IDX_W];

endmodule : quad_receiver

// File: quad_link_sva.sv
// Wire checks on the quadrature link
`timescale 1ns/1ps
`include "quad_defines.svh"
module quad_link_sva #(
    parameter int FAULT_HOLD_CYCLES = `FAULT_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic quad_channel_a,
    input wire logic quad_channel_a_n,
    input wire logic quad_channel_b,
    input wire logic quad_channel_b_n,
    input wire logic ref_pulse,
    input wire logic ref_pulse_n,
    input wire logic fault_n,
    input wire logic comm_u,
    input wire logic comm_u_n,
    input wire logic comm_v,
    input wire logic comm_v_n,
    input wire logic comm_w,
    input wire logic comm_w_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] low_q;
    logic [31:0] low_d;
    // Counts low samples; cleared while high
    always_comb low_d = fault_n ? 32'h0000_0000 : low_q + 32'h0000_0001;
    always_ff @(posedge clk) low_q <= rst ? 32'h0000_0000 : low_d;
    property p_one_edge;
        !($changed(quad_channel_a) && $changed(quad_channel_b));
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("a and b moved together");
    property p_space;
        $changed(quad_channel_a) || $changed(quad_channel_b)
            |=> ($stable(quad_channel_a) && $stable(quad_channel_b)) [*3];
    endproperty
    a_space: assert property (p_space) else $error("edges too close");
    property p_a_n;
        quad_channel_a_n == !quad_channel_a;
    endproperty
    a_a_n: assert property (p_a_n) else $error("a complement wrong");
    property p_b_n;
        quad_channel_b_n == !quad_channel_b;
    endproperty
    a_b_n: assert property (p_b_n) else $error("b complement wrong");
    property p_ref_n;
        ref_pulse_n == !ref_pulse;
    endproperty
    a_ref_n: assert property (p_ref_n) else $error("ref complement wrong");
    // Reference rises with the B edge going forward and the A edge going back, so only the levels are gated here
    property p_ref_gate;
        ref_pulse |-> quad_channel_a && quad_channel_b;
    endproperty
    a_ref_gate: assert property (p_ref_gate) else $error("ref outside a and b high");
    property p_ref_edge;
        $changed(ref_pulse) |-> $changed(quad_channel_a) || $changed(quad_channel_b);
    endproperty
    a_ref_edge: assert property (p_ref_edge) else $error("ref moved off a step");
    // Commutation valid one cycle after reset
    property p_comm_n;
        !$past(rst) |-> comm_u_n != comm_u && comm_v_n != comm_v && comm_w_n != comm_w;
    endproperty
    a_comm_n: assert property (p_comm_n) else $error("comm complement wrong");
    property p_fault_min;
        $fell(fault_n) |-> !fault_n [*8];
    endproperty
    a_fault_min: assert property (p_fault_min) else $error("fault pulse short");
    property p_fault_hold;
        $rose(fault_n) |-> low_q >= 32'(FAULT_HOLD_CYCLES);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault hold short");
    c_ref: cover property ($rose(ref_pulse));
    c_fault: cover property ($fell(fault_n));
    c_rev: cover property ($rose(quad_channel_b) && !quad_channel_a);
endmodule : quad_link_sva

// File: htl_quadrature_encoder_signals_tb.sv
// Bench joining encoder and receiver over the link
`timescale 1ns/1ps
module htl_quadrature_encoder_signals_tb;
    import quad_pkg::*;
    logic clk, rst, step_req, step_dir, malfunction, magnet_n, magnet_s, home_track;
    logic err_clear, step_ready, fault_active, rx_dir, ref_hit, count_error, shutdown;
    logic lim1, lim2, home, cu, cv, cw, berr;
    logic [31:0] enc_pos, rx_pos, ref_pos, bpos, exp_pos, exp_rx;
    comm_div_t comm_div;
    eval_mode_t eval_mode;
    int checks = 0;
    int n_mismatch = 0;
    quad_link_if link();
    quad_link_if bad();
    quad_link_if se();
    quad_encoder #(.COUNTS_PER_REV(16), .CPR_W(4), .FAULT_HOLD_CYCLES(20), .POS_DETECT(1'b1))
    u_quad_encoder (.clk(clk), .rst(rst), .step_req(step_req), .step_dir(step_dir),
        .malfunction(malfunction), .comm_div(comm_div), .magnet_n(magnet_n),
        .magnet_s(magnet_s), .home_track(home_track), .step_ready(step_ready),
        .position(enc_pos), .fault_active(fault_active), .link(link.encoder));
    // Single-ended build without position detection, fed in step with the first
    quad_encoder #(.COUNTS_PER_REV(16), .CPR_W(4), .FAULT_HOLD_CYCLES(20),
        .single_ended_variant(1'b1))
    u_quad_encoder_2 (.clk(clk), .rst(rst), .step_req(step_req), .step_dir(step_dir),
        .malfunction(malfunction), .comm_div(comm_div), .magnet_n(magnet_n),
        .magnet_s(magnet_s), .home_track(home_track), .step_ready(),
        .position(), .fault_active(), .link(se.encoder));
    quad_receiver u_quad_receiver (.clk(clk), .rst(rst), .eval_mode(eval_mode),
        .err_clear(err_clear), .link(link.receiver), .position(rx_pos), .direction(rx_dir),
        .ref_position(ref_pos), .ref_hit(ref_hit), .count_error(count_error),
        .shutdown(shutdown), .limit_1(lim1), .limit_2(lim2), .home(home), .comm_u(cu),
        .comm_v(cv), .comm_w(cw));
    // Second receiver fed by a rule-breaking driver
    quad_receiver u_quad_receiver_2 (.clk(clk), .rst(rst), .eval_mode(eval_mode),
        .err_clear(err_clear), .link(bad.receiver), .position(bpos), .direction(),
        .ref_position(), .ref_hit(), .count_error(berr), .shutdown(), .limit_1(),
        .limit_2(), .home(), .comm_u(), .comm_v(), .comm_w());
    quad_link_sva #(.FAULT_HOLD_CYCLES(20)) u_quad_link_sva (.clk(clk), .rst(rst),
        .quad_channel_a(link.quad_channel_a), .quad_channel_a_n(link.quad_channel_a_n),
        .quad_channel_b(link.quad_channel_b), .quad_channel_b_n(link.quad_channel_b_n),
        .ref_pulse(link.ref_pulse), .ref_pulse_n(link.ref_pulse_n), .fault_n(link.fault_n),
        .comm_u(link.comm_u), .comm_u_n(link.comm_u_n), .comm_v(link.comm_v),
        .comm_v_n(link.comm_v_n), .comm_w(link.comm_w), .comm_w_n(link.comm_w_n));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic c1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : c1
    task automatic c32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : c32
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic comm(input logic rx);
        int n, seg;
        n = int'(comm_div) + 2;
        seg = int'(exp_pos[3:0]) * n / 16;
        c1(rx ? cu : link.comm_u, seg == 0);
        c1(rx ? cv : link.comm_v, seg == 1 % n);
        c1(rx ? cw : link.comm_w, seg == 2 % n);
    endtask : comm
    task automatic step(input logic dir);
        for (int i = 0; i < 20 && step_ready !== 1'b1; i++)
            @(negedge clk);
        step_dir = dir;
        step_req = 1'b1;
        @(negedge clk);
        step_req = 1'b0;
        exp_pos = dir ? exp_pos + 32'h0000_0001 : exp_pos - 32'h0000_0001;
        @(negedge clk);
        c1(link.quad_channel_a, exp_pos[1] ^ exp_pos[0]);
        c1(link.quad_channel_b, exp_pos[1]);
        c32(enc_pos, exp_pos);
        c1(step_ready, 1'b0);
        c1(se.quad_channel_a_n | se.quad_channel_b_n | se.ref_pulse_n, 1'b0);
        c1(se.quad_channel_b, exp_pos[1]);
        comm(1'b0);
    endtask : step
    task automatic t_reset;
        // Count rising edges so the clock's first transition cannot shorten reset
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cyc(1);
        c32(rx_pos, 32'h0000_0000);
        c1(link.fault_n, 1'b1);
        c1(shutdown, 1'b0);
        c1(step_ready, 1'b1);
        $display("reset done");
    endtask : t_reset
    task automatic t_ref;
        step(1'b1);
        step(1'b1);
        c1(link.ref_pulse, 1'b1);
        for (int i = 0; i < 10 && ref_hit !== 1'b1; i++)
            @(negedge clk);
        c1(ref_hit, 1'b1);
        c32(ref_pos, 32'h0000_0002);
        step(1'b1);
        c1(link.ref_pulse, 1'b0);
        exp_rx = 32'h0000_0003;
        $display("ref done");
    endtask : t_ref
    task automatic t_modes;
        eval_mode_t m[3] = '{EVAL_X4, EVAL_X2, EVAL_X1};
        int d[3] = '{8, 4, 2};
        for (int k = 0; k < 3; k++)
        begin
            eval_mode = m[k];
            repeat (8) step(1'b1);
            cyc(8);
            exp_rx = exp_rx + 32'(d[k]);
            c32(rx_pos, exp_rx);
        end
        c1(rx_dir, 1'b1);
        eval_mode = EVAL_X4;
        repeat (4) step(1'b0);
        cyc(8);
        c32(rx_pos, exp_rx - 32'h0000_0004);
        c1(rx_dir, 1'b0);
        exp_rx = exp_rx - 32'h0000_0004;
        $display("modes done");
    endtask : t_modes
    task automatic t_comm;
        for (int d = 0; d < 3; d++)
        begin
            comm_div = comm_div_t'(d);
            repeat (4) step(1'b1);
            cyc(6);
            comm(1'b1);
        end
        c32(rx_pos, exp_rx + 32'h0000_000c);
        c1(count_error, 1'b0);
        $display("comm done");
    endtask : t_comm
    task automatic t_fault;
        int low;
        low = 6;
        malfunction = 1'b1;
        cyc(2);
        malfunction = 1'b0;
        c1(fault_active, 1'b1);
        cyc(5);
        c1(shutdown, 1'b1);
        for (int i = 0; i < 100 && link.fault_n !== 1'b1; i++)
        begin
            low++;
            @(negedge clk);
        end
        c1(low >= 20 && low < 30, 1'b1);
        cyc(6);
        c1(shutdown, 1'b0);
        $display("fault done");
    endtask : t_fault
    task automatic t_lim;
        for (int i = 0; i < 4; i++)
        begin
            {magnet_s, magnet_n} = 2'(i);
            home_track = magnet_s ^ magnet_n;
            cyc(6);
            c1(lim1, magnet_n);
            c1(lim2, magnet_s);
            c1(home, home_track);
            c1(se.home_out, 1'b0);
        end
        $display("limits done");
    endtask : t_lim
    task automatic t_bad;
        logic [1:0] seq[4] = '{2'h2, 2'h3, 2'h1, 2'h0};
        // Edges at three cycles, under the nominal four
        for (int k = 0; k < 4; k++)
        begin
            {bad.quad_channel_a, bad.quad_channel_b} = seq[k];
            cyc(3);
        end
        cyc(6);
        c32(bpos, 32'h0000_0004);
        c1(berr, 1'b0);
        {bad.quad_channel_a, bad.quad_channel_b} = 2'h3;
        cyc(6);
        c1(berr, 1'b1);
        c32(bpos, 32'h0000_0004);
        err_clear = 1'b1;
        cyc(1);
        err_clear = 1'b0;
        cyc(1);
        c1(berr, 1'b0);
        $display("bad link done");
    endtask : t_bad
    initial
    begin
        {rst, step_req, step_dir, malfunction, magnet_n, magnet_s, home_track} = 7'h40;
        err_clear = 1'b0;
        comm_div = COMM_2X180;
        eval_mode = EVAL_X4;
        exp_pos = 32'h0000_0000;
        exp_rx = 32'h0000_0000;
        {bad.quad_channel_a, bad.quad_channel_a_n, bad.quad_channel_b} = 3'h0;
        {bad.quad_channel_b_n, bad.ref_pulse, bad.ref_pulse_n, bad.fault_n} = 4'h1;
        {bad.comm_u, bad.comm_u_n, bad.comm_v, bad.comm_v_n, bad.comm_w} = 5'h00;
        {bad.comm_w_n, bad.limit_out_1, bad.limit_out_2, bad.home_out} = 4'h0;
        t_reset;
        t_ref;
        t_modes;
        t_comm;
        t_fault;
        t_lim;
        t_bad;
        close_out;
    end
    initial
    begin
        #100000;
        n_mismatch++;
        close_out;
    end
endmodule : htl_quadrature_encoder_signals_tb
